// File: design/cscan_map.vh
// register offsets, field positions, reset values and decode codes of the scan/drive block
`ifndef CSCAN_MAP_VH
`define CSCAN_MAP_VH
`define CSCAN_ADDR_SCAN_SETUP   8'h1b
`define CSCAN_ADDR_SOFT_RESET   8'h1c
`define CSCAN_ADDR_CH0_DRIVE    8'h1e
`define CSCAN_ADDR_CH1_DRIVE    8'h1f
`define CSCAN_ADDR_CH2_DRIVE    8'h20
`define CSCAN_ADDR_CH3_DRIVE    8'h21
`define CSCAN_SCAN_ON_BIT       15
`define CSCAN_LIST_HI           14
`define CSCAN_LIST_LO           13
`define CSCAN_FIXED_HI          12
`define CSCAN_FIXED_LO          3
`define CSCAN_FILT_HI           2
`define CSCAN_FILT_LO           0
`define CSCAN_RESET_BIT         15
`define CSCAN_DRV_HI            15
`define CSCAN_DRV_LO            11
`define CSCAN_CAL_HI            10
`define CSCAN_CAL_LO            6
`define CSCAN_SCAN_SETUP_RST    16'h0_20f
`define CSCAN_DRIVE_RST         5'h0_0
`define CSCAN_FIXED_PATTERN     10'h0_41
`define CSCAN_FILT_RST          3'h7
`define CSCAN_LIST_2CH_A        2'h0
`define CSCAN_LIST_3CH          2'h1
`define CSCAN_LIST_4CH          2'h2
`define CSCAN_FILT_1M0          3'h1
`define CSCAN_FILT_3M3          3'h4
`define CSCAN_FILT_10M          3'h5
`define CSCAN_FILT_33M          3'h7
`endif

// File: design/cscan_seq.v
// channel sequencer: single channel or round-robin scan list
`timescale 1ns/1ns
`include "cscan_map.vh"
module cscan_seq (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire       sw_reset,
  // configuration
  input  wire       scan_on,
  input  wire [1:0] list,
  input  wire [1:0] pick,
  input  wire       four_ch,
  // conversion engine handshake
  input  wire       conv_done,
  output reg  [1:0] chan_q
);
  reg  [1:0] last_ch;
  reg  [1:0] chan_d;

  always @* begin
    case (list)
      `CSCAN_LIST_3CH: last_ch = four_ch ? 2'h2 : 2'h1;
      `CSCAN_LIST_4CH: last_ch = four_ch ? 2'h3 : 2'h1;
      default:         last_ch = 2'h1;
    endcase
  end

  always @* begin
    chan_d = chan_q;
    if (!scan_on)
      chan_d = four_ch ? pick : {1'b0, pick[0]};
    else if (conv_done)
      chan_d = (chan_q >= last_ch) ? 2'h0 : chan_q + 2'h1;
    else if (chan_q > last_ch)
      chan_d = 2'h0; // list shrunk mid-scan: restart
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      chan_q <= 2'h0;
    else if (sw_reset)
      chan_q <= 2'h0;
    else
      chan_q <= chan_d;
  end
endmodule // cscan_seq

// File: design/cscan_top.v
// scan setup, soft reset and per-channel drive level registers
// How it works
// - scan off: convert continuously on the single picked channel only
// - scan on: convert across channels of the scan channel list
// - scan: one conversion per listed channel in order, then restart
// - list 00 and 11 give 0,1; 01 gives 0-2; 10 gives 0-3; with NCH of 2 or less the code gives 0,1 for every list
// - filter field 001/100/101/111 give 1.0/3.3/10/33 MHz; resets to 111
// - writing one to reset bit resets device; bit reads zero
// - drive level field sets channel current only under manual override
// - calibrated field captures initial calibration current; resets zero
// - calibrated field refreshed after each correction while tracking on
// - single channel pick selects channel 0 to 3 by value; with NCH of 2 or less the code uses pick bit 0 only, channel 0 or 1
// - tracking off stops correction and freezes calibrated fields
`timescale 1ns/1ns
`include "cscan_map.vh"
module cscan_top #(
  parameter NCH = 4
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  // main configuration fields held elsewhere
  input  wire [1:0]  single_channel_pick,
  input  wire        manual_drive_override,
  input  wire        amplitude_tracking_off,
  // amplitude calibration engine
  input  wire        conv_done,
  input  wire        amp_cal_done,
  input  wire [4:0]  amp_cal_level,
  // outputs to converter core
  output wire [1:0]  active_channel,
  output reg         multi_channel_scan_on,
  output reg  [2:0]  filter_bw_sel,
  output reg         filter_bw_valid,
  output reg  [4:0]  drive_level,
  output reg         drive_from_reg,
  output reg         soft_reset_trigger
);
  localparam FOUR_CH = (NCH > 2) ? 1'b1 : 1'b0;

  reg  [1:0]  scan_channel_list;
  reg  [9:0]  fixed_q;
  reg  [2:0]  filt_q;
  reg  [4:0]  drv_q [0:3];
  reg  [4:0]  cal_q [0:3];
  reg  [3:0]  ch_hit;
  reg  [15:0] rd_d;
  wire        rst_wr;

  assign rst_wr = reg_wr && (reg_addr == `CSCAN_ADDR_SOFT_RESET) &&
                  reg_wdata[`CSCAN_RESET_BIT];

  // one-cycle pulse; the same pulse clears everything here except drive_level, drive_from_reg and reg_rdata
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      soft_reset_trigger <= 1'b0;
    else
      soft_reset_trigger <= rst_wr;
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      multi_channel_scan_on <= 1'b0;
      scan_channel_list     <= `CSCAN_LIST_2CH_A;
      fixed_q               <= `CSCAN_FIXED_PATTERN;
      filt_q                <= `CSCAN_FILT_RST;
    end else if (soft_reset_trigger) begin
      multi_channel_scan_on <= 1'b0;
      scan_channel_list     <= `CSCAN_LIST_2CH_A;
      fixed_q               <= `CSCAN_FIXED_PATTERN;
      filt_q                <= `CSCAN_FILT_RST;
    end else if (reg_wr && reg_addr == `CSCAN_ADDR_SCAN_SETUP) begin
      multi_channel_scan_on <= reg_wdata[`CSCAN_SCAN_ON_BIT];
      scan_channel_list     <= reg_wdata[`CSCAN_LIST_HI:`CSCAN_LIST_LO];
      fixed_q               <= reg_wdata[`CSCAN_FIXED_HI:`CSCAN_FIXED_LO];
      filt_q                <= reg_wdata[`CSCAN_FILT_HI:`CSCAN_FILT_LO];
    end
  end

  // filter decode: unlisted codes fall back to widest band
  always @* begin
    filter_bw_valid = 1'b1;
    case (filt_q)
      `CSCAN_FILT_1M0: filter_bw_sel = `CSCAN_FILT_1M0;
      `CSCAN_FILT_3M3: filter_bw_sel = `CSCAN_FILT_3M3;
      `CSCAN_FILT_10M: filter_bw_sel = `CSCAN_FILT_10M;
      `CSCAN_FILT_33M: filter_bw_sel = `CSCAN_FILT_33M;
      default: begin
        filter_bw_sel   = `CSCAN_FILT_33M;
        filter_bw_valid = 1'b0;
      end
    endcase
  end

  cscan_seq u_seq (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .sw_reset  (soft_reset_trigger),
    .scan_on   (multi_channel_scan_on),
    .list      (scan_channel_list),
    .pick      (single_channel_pick),
    .four_ch   (FOUR_CH),
    .conv_done (conv_done),
    .chan_q    (active_channel)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      // channel index as a 2-bit constant; a genvar takes no part-select
      localparam [1:0] CH_IDX = g;
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          drv_q[g] <= `CSCAN_DRIVE_RST;
          cal_q[g] <= `CSCAN_DRIVE_RST;
        end else if (soft_reset_trigger) begin
          drv_q[g] <= `CSCAN_DRIVE_RST;
          cal_q[g] <= `CSCAN_DRIVE_RST;
        end else begin
          if (reg_wr && ch_hit[g])
            drv_q[g] <= reg_wdata[`CSCAN_DRV_HI:`CSCAN_DRV_LO]; // cal bits dropped
          if (amp_cal_done && !amplitude_tracking_off &&
              active_channel == CH_IDX)
            cal_q[g] <= amp_cal_level;
        end
      end
    end
  endgenerate

  always @* begin
    ch_hit = 4'h0;
    if (reg_addr == `CSCAN_ADDR_CH0_DRIVE) ch_hit[0] = 1'b1;
    if (reg_addr == `CSCAN_ADDR_CH1_DRIVE) ch_hit[1] = 1'b1;
    if (reg_addr == `CSCAN_ADDR_CH2_DRIVE) ch_hit[2] = FOUR_CH;
    if (reg_addr == `CSCAN_ADDR_CH3_DRIVE) ch_hit[3] = FOUR_CH;
  end

  // current for the channel being converted
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      drive_level    <= 5'h0_0;
      drive_from_reg <= 1'b0;
    end else begin
      drive_from_reg <= manual_drive_override;
      drive_level    <= manual_drive_override ? drv_q[active_channel]
                                              : cal_q[active_channel];
    end
  end

  always @* begin
    rd_d = 16'h0000;
    case (reg_addr)
      `CSCAN_ADDR_SCAN_SETUP:
        rd_d = {multi_channel_scan_on, scan_channel_list, fixed_q, filt_q};
      `CSCAN_ADDR_SOFT_RESET: rd_d = 16'h0000;
      default: begin
        if (ch_hit[0]) rd_d = {drv_q[0], cal_q[0], 6'h00};
        if (ch_hit[1]) rd_d = {drv_q[1], cal_q[1], 6'h00};
        if (ch_hit[2]) rd_d = {drv_q[2], cal_q[2], 6'h00};
        if (ch_hit[3]) rd_d = {drv_q[3], cal_q[3], 6'h00};
      end
    endcase
  end

  // registered read data, one cycle after address
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= rd_d;
  end
endmodule // cscan_top

// File: verification/cscan_props.sv
// assertion checker for the scan setup and drive level block
`timescale 1ns/1ns
module cscan_props (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // control and status
  input wire logic [1:0]  single_channel_pick,
  input wire logic        manual_drive_override,
  input wire logic        conv_done,
  input wire logic [1:0]  active_channel,
  input wire logic        multi_channel_scan_on,
  input wire logic [2:0]  filter_bw_sel,
  input wire logic        filter_bw_valid,
  input wire logic        drive_from_reg,
  input wire logic        soft_reset_trigger
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // a write in the trigger cycle stretches the pulse, so it is left out
  sequence s_rst_wr;
    reg_wr && reg_addr == 8'h1c && reg_wdata[15] && !soft_reset_trigger;
  endsequence
  sequence s_pulse;
    soft_reset_trigger ##1 !soft_reset_trigger;
  endsequence
  property p_trig; s_rst_wr |=> s_pulse; endproperty
  a_trig: assert property (p_trig)
    else $error("reset trigger missing or too long");
  property p_rst; soft_reset_trigger |=> !multi_channel_scan_on && filter_bw_sel == 3'h7;
  endproperty
  a_rst: assert property (p_rst)
    else $error("setup not back at reset value");
  property p_scan; reg_wr && reg_addr == 8'h1b && !soft_reset_trigger
    |=> multi_channel_scan_on == $past(reg_wdata[15]); endproperty
  a_scan: assert property (p_scan)
    else $error("scan enable not taken from write");
  property p_single; !multi_channel_scan_on && conv_done && !soft_reset_trigger
    && $stable(single_channel_pick) |=> active_channel == $past(single_channel_pick); endproperty
  a_single: assert property (p_single)
    else $error("single channel not followed");
  property p_step; multi_channel_scan_on && conv_done && active_channel == 2'h0
    && !soft_reset_trigger |=> active_channel == 2'h1; endproperty
  a_step: assert property (p_step)
    else $error("scan did not step to channel one");
  property p_filt; filter_bw_sel inside {3'h1, 3'h4, 3'h5, 3'h7}
    && (filter_bw_valid || filter_bw_sel == 3'h7); endproperty
  a_filt: assert property (p_filt)
    else $error("filter code outside decode");
  property p_ovr; manual_drive_override [*2] |-> drive_from_reg; endproperty
  a_ovr: assert property (p_ovr)
    else $error("override not followed");
  property p_rdrst; reg_addr == 8'h1c |=> reg_rdata == 16'h0000; endproperty
  a_rdrst: assert property (p_rdrst)
    else $error("reset register read not zero");
endmodule // cscan_props

// File: verification/cscan_bench.sv
// self-checking bench for the scan setup and drive level block
`timescale 1ns/1ns
module cscan_bench;
  logic clk_sys = 0, rstn = 0, reg_wr = 0, conv_done = 0, amp_cal_done = 0;
  logic manual_drive_override = 0, amplitude_tracking_off = 0;
  logic [7:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic [1:0] single_channel_pick = 0, ch;
  logic [4:0] amp_cal_level = 0;
  wire [15:0] reg_rdata;
  wire [1:0] active_channel;
  wire [2:0] filter_bw_sel;
  wire [4:0] drive_level;
  wire multi_channel_scan_on, filter_bw_valid, drive_from_reg, soft_reset_trigger;
  int failures, n_tests, cyc, n;
  int unsigned seed = 11702;
  logic [15:0] m [0:255];
  cscan_top i_cscan_top (.clk_sys, .rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .single_channel_pick, .manual_drive_override, .amplitude_tracking_off, .conv_done,
    .amp_cal_done, .amp_cal_level, .active_channel, .multi_channel_scan_on, .filter_bw_sel,
    .filter_bw_valid, .drive_level, .drive_from_reg, .soft_reset_trigger);
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc > 3000) begin
    failures++;
    close_out;
  end
  task tick; @(posedge clk_sys); #1; endtask
  function int unsigned rnd; seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed; endfunction
  task chk(input logic [15:0] s, e); n_tests++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end endtask
  task mrst; for (int a = 0; a < 256; a++) m[a] = 16'h0000; m[27] = 16'h020f; endtask
  // cal bits and low bits of drive writes are dropped: hardware owns them
  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = 1; tick; reg_wr = 0;
    if (a == 8'h1b) m[a] = d;
    else if (a > 8'h1d && a < 8'h22) m[a] = {d[15:11], m[a][10:6], 6'h00};
  endtask
  task rd(input logic [7:0] a); reg_addr = a; tick; chk(reg_rdata, m[a]); endtask
  task pulse; conv_done = 1; tick; conv_done = 0; endtask
  task cal(input logic [4:0] l); amp_cal_level = l; amp_cal_done = 1; tick; amp_cal_done = 0;
    if (!amplitude_tracking_off) m[30 + ch][10:6] = l; endtask
  task close_out; $display("tests=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish; endtask
  initial begin
    int c[5] = '{1, 4, 5, 7, 0};
    mrst; repeat (6) tick; rstn = 1;
    for (int a = 27; a < 35; a++) rd(8'(a));
    $display("T1 reset values done");
    // every listed bandwidth is programmed in turn, lowest first
    for (int i = 0; i < 5; i++) begin
      wr(8'h1b, {3'h0, 10'h041, 3'(c[i])}); rd(8'h1b);
      chk(16'(filter_bw_sel), 16'(i < 4 ? c[i] : 7));
      chk(16'(filter_bw_valid), 16'(i < 4));
    end
    $display("T2 filter done");
    for (int p = 0; p < 4; p++) begin
      single_channel_pick = 2'(p); pulse; chk(16'(active_channel), 16'(p));
    end
    for (int l = 0; l < 4; l++) begin
      // scan off first, so the pulse parks the sequencer on channel 0
      wr(8'h1b, 16'h020f);
      single_channel_pick = 0; pulse; ch = 0; wr(8'h1b, {1'b1, 2'(l), 13'h020f});
      n = l == 1 ? 3 : l == 2 ? 4 : 2;
      chk(16'(multi_channel_scan_on), 16'h0001);
      for (int k = 0; k < 2 * n; k++) begin
        pulse; ch = 2'((ch + 1) % n); chk(16'(active_channel), 16'(ch));
      end
    end
    wr(8'h1b, 16'h020f);
    $display("T3 channel order done");
    for (int k = 0; k < 4; k++) begin
      single_channel_pick = 2'(k); pulse; ch = 2'(k);
      // scan is off here, so each pick sets the channel
      wr(8'(30 + k), 16'(rnd()) & 16'hf800);
      cal(5'(rnd())); rd(8'(30 + k));
      manual_drive_override = 0; tick; tick;
      chk(16'(drive_level), 16'(m[30 + k][10:6]));
      manual_drive_override = 1; tick; tick;
      chk(16'(drive_level), 16'(m[30 + k][15:11]));
      chk(16'(drive_from_reg), 16'h0001);
      amplitude_tracking_off = 1; cal(5'(rnd())); rd(8'(30 + k));
      amplitude_tracking_off = 0;
    end
    $display("T4 drive levels done");
    wr(8'h1b, 16'hc20f); wr(8'h1c, 16'h8000); tick; tick; mrst;
    for (int a = 27; a < 34; a++) rd(8'(a));
    $display("T5 soft reset done");
    close_out;
  end
endmodule // cscan_bench
bind cscan_top cscan_props i_cscan_props (.clk_sys, .rstn, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rdata, .single_channel_pick, .manual_drive_override, .conv_done, .active_channel,
  .multi_channel_scan_on, .filter_bw_sel, .filter_bw_valid, .drive_from_reg,
  .soft_reset_trigger);
